// ==== verilog/sbsram_cycle_decode.sv ====
// Cycle decoder and byte-write control of a pipelined burst SRAM.
// Assumes a bus master on clk_sys and an array with combinational read.
// How it works
// R01: Bad selects with a strobe deselect, float data; primary off with only the processor strobe low does not deselect
// R02: Sleep request forces sleep and floats data
// R03: Processor strobe when selected starts read burst
// R04: Controller strobe starts burst, write term decides
// R05: Burst advance low steps to next address
// R06: Burst advance high repeats at current address
// R07: Write when global write or gated lane low
// R08: Global writes all lanes, else chosen lanes
// R09: Reads drive data only with enable low
// R10: Output enable acts combinationally, never registered
// R11: Output enable masked during write cycles
// R12: Master raises output enable before writes
// R13: Master writes never in processor-strobe cycle
// R14: Two-bit burst counter, interleaved or linear
`timescale 1ns/1ps
module sbsram_cycle_decode
  import sbsram_pkg::*;
(
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic primary_select_n, // Primary chip select, low active
  input wire logic high_active_select, // Secondary select, high active
  input wire logic low_active_select_n, // Secondary select, low active
  input wire logic sleep_request, // Asynchronous sleep pin, high active
  input wire logic cpu_address_strobe_n, // Processor address strobe
  input wire logic ctrl_address_strobe_n, // Controller address strobe
  input wire logic burst_step_n, // Burst advance, low steps
  input wire logic global_write_n, // Global write, low writes all lanes
  input wire logic byte_write_gate_n, // Byte-write gate, low active
  input wire logic [LANES-1:0] lane_write_n, // Per-lane write enables
  input wire logic burst_order, // 1 interleaved, 0 linear
  input wire logic output_enable_n, // Asynchronous output enable
  input wire logic [ADDR_W-1:0] addrIn, // External word address
  input wire logic [DATA_W-1:0] dqIn, // Data pins, input side
  output logic [DATA_W-1:0] dqOut, // Data pins, output side
  output logic dqOe_n, // Data pin enable, low while driving
  output logic [ADDR_W-1:0] memAddr, // Array word address
  output logic [LANES-1:0] memLaneWe, // Array lane write strobes
  output logic [DATA_W-1:0] memWdata, // Array write data
  input wire logic [DATA_W-1:0] memRdata, // Array read data
  output logic sleepActive // Device is in sleep
);

  ////////////////////////////////////////////////////////////////////////////
  // Lane decode from the write controls
  function automatic logic [LANES-1:0] laneDecode(
    input logic gw_n,
    input logic gate_n,
    input logic [LANES-1:0] lanes_n
  );
    logic [LANES-1:0] sel;
    sel = LANES_NONE;
    if (!gw_n) begin // Global write hits every lane [R08]
      sel = LANES_ALL;
    end else if (!gate_n) begin // Gated, any lane mix is legal [R08]
      sel = ~lanes_n;
    end
    return sel;
  endfunction

  logic sleepS1_r; // First sync stage, read only by the second
  logic sleepS2_r; // Second sync stage
  logic sleepS3_r; // Third sync stage
  logic sleepNow_r; // Filtered sleep level
  sbsram_cycle_t cycle_r; // Operation of the current cycle
  sbsram_cycle_t cycle_nxt; // Operation decided at this rise
  logic burstLive_r; // A burst has been started and not ended
  logic [ADDR_W-1:0] baseAddr_r; // Address taken at burst start
  logic [LANES-1:0] lanes_r; // Lanes of the current write
  logic [DATA_W-1:0] wdata_r; // Registered write data
  logic [DATA_W-1:0] dataOut_r; // Read data output stage
  logic readOut_r; // Output stage holds read data
  logic [BURST_W-1:0] offs; // Low burst address bits
  logic [LANES-1:0] laneSel; // Lanes decoded now
  logic isWrite; // Decoded write term, high for write
  logic secOk; // Both secondary selects active
  logic selected; // All three selects active
  logic loadBurst; // Start a burst at the external address
  logic stepBurst; // Step to the next burst address
  logic contCyc; // Continue or suspend condition

  ////////////////////////////////////////////////////////////////////////////
  // Sleep pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleepS1_r <= 1'b0;
      sleepS2_r <= 1'b0;
      sleepS3_r <= 1'b0;
      sleepNow_r <= 1'b0;
    end else begin
      sleepS1_r <= sleep_request;
      sleepS2_r <= sleepS1_r;
      sleepS3_r <= sleepS2_r;
      if (sleepS2_r == sleepS3_r) begin
        sleepNow_r <= sleepS2_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode of this rise
  assign laneSel = laneDecode(global_write_n, byte_write_gate_n, lane_write_n);
  assign isWrite = |laneSel; // Write term [R07]
  assign secOk = high_active_select & ~low_active_select_n;
  assign selected = ~primary_select_n & secOk;
  assign contCyc = ctrl_address_strobe_n & (cpu_address_strobe_n | primary_select_n);

  // Priority: sleep, deselect, processor start, controller start, continue
  always_comb begin
    cycle_nxt = CYC_IDLE;
    loadBurst = 1'b0;
    stepBurst = 1'b0;
    if (sleepNow_r) begin // Sleep overrides every input [R02]
      cycle_nxt = CYC_SLEEP;
    end else if (primary_select_n && !ctrl_address_strobe_n) begin // [R01]
      cycle_nxt = CYC_IDLE;
    end else if (!primary_select_n && !secOk
                 && !(cpu_address_strobe_n && ctrl_address_strobe_n)) begin // [R01]
      cycle_nxt = CYC_IDLE;
    end else if (selected && !cpu_address_strobe_n) begin
      cycle_nxt = CYC_READ; // Write controls ignored here [R03]
      loadBurst = 1'b1;
    end else if (selected && !ctrl_address_strobe_n) begin
      cycle_nxt = isWrite ? CYC_WRITE : CYC_READ; // [R04]
      loadBurst = 1'b1;
    end else if (contCyc && burstLive_r) begin
      cycle_nxt = isWrite ? CYC_WRITE : CYC_READ; // [R05] [R06]
      stepBurst = ~burst_step_n; // Advance low steps, high holds [R05] [R06]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst counter for the low address bits
  sbsram_burst_ctr u_burst (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(loadBurst),
    .step(stepBurst),
    .interleaved(burst_order),
    .seed(addrIn[BURST_W-1:0]),
    .offs(offs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state and burst liveness; continuing without a start stays idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cycle_r <= CYC_IDLE;
      burstLive_r <= 1'b0;
    end else begin
      cycle_r <= cycle_nxt;
      if (loadBurst) begin
        burstLive_r <= 1'b1;
      end else if (cycle_nxt == CYC_IDLE || cycle_nxt == CYC_SLEEP) begin
        burstLive_r <= 1'b0; // Pending burst dropped on deselect or sleep
      end
    end
  end

  // External address taken only at a burst start; none used otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      baseAddr_r <= ADDR_RST;
    end else if (loadBurst) begin // [R03] [R04]
      baseAddr_r <= addrIn;
    end
  end

  // Write lanes and data registered at the rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lanes_r <= LANES_NONE;
      wdata_r <= DATA_RST;
    end else begin
      lanes_r <= (cycle_nxt == CYC_WRITE) ? laneSel : LANES_NONE; // [R08]
      wdata_r <= dqIn;
    end
  end

  // Read output stage; deselect or write empties it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dataOut_r <= DATA_RST;
      readOut_r <= 1'b0;
    end else begin
      readOut_r <= (cycle_r == CYC_READ);
      if (cycle_r == CYC_READ) begin
        dataOut_r <= memRdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; enable and sleep pin gate the drivers without a clock, so the
  // float follows the pins at once rather than a cycle late
  assign memAddr = {baseAddr_r[ADDR_W-1:BURST_W], offs};
  assign memLaneWe = lanes_r;
  assign memWdata = wdata_r;
  assign dqOut = dataOut_r;
  assign dqOe_n = ~(readOut_r && !output_enable_n && !sleep_request
                    && cycle_r != CYC_WRITE && !sleepNow_r); // [R09] [R10] [R11] [R02]
  assign sleepActive = (cycle_r == CYC_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the decoder
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_deselect;
    !sleepNow_r && primary_select_n && !ctrl_address_strobe_n;
  endsequence
  sequence s_idle_then_float;
    (cycle_r == CYC_IDLE) ##1 dqOe_n;
  endsequence

  a_deselect_float: assert property (s_deselect |=> s_idle_then_float) // [R01]
    else $error("deselect did not float data");
  a_sleep_float: assert property (sleep_request |-> dqOe_n) // [R02]
    else $error("data driven while sleep requested");
  a_sleep_state: assert property (sleepNow_r |=> cycle_r == CYC_SLEEP) // [R02]
    else $error("sleep level did not force sleep");
  a_cpu_read_start: assert property (!sleepNow_r && selected && !cpu_address_strobe_n // [R03]
    |=> cycle_r == CYC_READ && memAddr == $past(addrIn))
    else $error("processor strobe did not start read");
  a_ctrl_start_kind: assert property (!sleepNow_r && selected && cpu_address_strobe_n // [R04]
    && !ctrl_address_strobe_n |=> (cycle_r == CYC_WRITE) == $past(isWrite))
    else $error("controller start has wrong kind");
  a_burst_step_addr: assert property (cycle_nxt != CYC_SLEEP && contCyc && burstLive_r // [R05]
    && !burst_step_n |=> memAddr[ADDR_W-1:BURST_W] == $past(memAddr[ADDR_W-1:BURST_W])
    && memAddr[BURST_W-1:0] != $past(memAddr[BURST_W-1:0]))
    else $error("burst did not step");
  a_burst_hold_addr: assert property (cycle_nxt != CYC_SLEEP && contCyc && burstLive_r // [R06]
    && burst_step_n |=> $stable(memAddr))
    else $error("suspended burst moved");
  a_global_write_lanes: assert property (cycle_nxt == CYC_WRITE && !global_write_n // [R08]
    |=> memLaneWe == LANES_ALL)
    else $error("global write missed lanes");
  // Judged from the cycle kind one clock back, not from the output stage flag
  a_read_drive_oe: assert property ($past(cycle_r) == CYC_READ && cycle_r != CYC_WRITE // [R09]
    && !output_enable_n && !sleep_request && !sleepNow_r |-> !dqOe_n)
    else $error("read data not driven");
  a_oe_float: assert property (output_enable_n |-> dqOe_n) // [R10]
    else $error("drivers on with enable high");
  a_write_mask: assert property (cycle_r == CYC_WRITE // [R11]
    |-> dqOe_n && memLaneWe != LANES_NONE)
    else $error("data driven in write cycle");
endmodule

// ==== verilog/sbsram_pkg.sv ====
// Shared constants and types of the burst SRAM cycle decoder.
// Assumes a single system clock; imported whole by every design module.
package sbsram_pkg;
  localparam int ADDR_W = 19; // Word address width
  localparam int LANES = 4; // Byte lanes
  localparam int LANE_W = 9; // Eight data bits plus one parity bit
  localparam int DATA_W = LANES * LANE_W; // Full data word
  localparam int BURST_W = 2; // Burst counter width, low address bits
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000; // Address after reset
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000; // Data after reset
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0; // Burst offset after reset
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1; // Counter step
  localparam logic [LANES-1:0] LANES_NONE = 4'h0; // No lane written
  localparam logic [LANES-1:0] LANES_ALL = 4'hF; // Every lane written
  // Operation taken at a clock rise
  typedef enum logic [1:0] {CYC_IDLE, CYC_SLEEP, CYC_READ, CYC_WRITE} sbsram_cycle_t;
endpackage

// ==== verilog/sbsram_burst_ctr.sv ====
// Two-bit wrapping burst counter producing the low word address bits.
// Assumes load and step are never high together; load wins if they are.
`timescale 1ns/1ps
module sbsram_burst_ctr
  import sbsram_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic load, // Start of burst, take seed
  input wire logic step, // Advance to the next burst word
  input wire logic interleaved, // 1 interleaved order, 0 linear order
  input wire logic [BURST_W-1:0] seed, // Low address bits at burst start
  output logic [BURST_W-1:0] offs // Current low address bits
);
  logic [BURST_W-1:0] base_r; // Seed of the running burst
  logic [BURST_W-1:0] count_r; // Words stepped so far, wraps at four
  logic [BURST_W-1:0] count_nxt; // Count after one step
  logic [BURST_W-1:0] offs_r; // Registered offset

  assign count_nxt = count_r + BURST_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and offset; order picked per step so a mode change applies at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_r <= BURST_RST;
      count_r <= BURST_RST;
      offs_r <= BURST_RST;
    end else if (load) begin
      base_r <= seed;
      count_r <= BURST_RST;
      offs_r <= seed;
    end else if (step) begin
      count_r <= count_nxt;
      if (interleaved) begin // Exclusive-or order [R14]
        offs_r <= base_r ^ count_nxt;
      end else begin // Linear wrap order [R14]
        offs_r <= base_r + count_nxt;
      end
    end
  end

  assign offs = offs_r;
endmodule

// ==== test/sbsram_master_model.sv ====
// Bus master model driving control, address and data pins of the decoder.
// Assumes the bench calls put once a cycle; pins move after falling edges.
`timescale 1ns/1ps
module sbsram_master_model
  import sbsram_pkg::*;
(
  input wire logic clk_sys, // System clock
  output logic primary_select_n, // Primary select
  output logic high_active_select, // Secondary select
  output logic low_active_select_n, // Secondary select, low
  output logic cpu_address_strobe_n, // Processor strobe
  output logic ctrl_address_strobe_n, // Controller strobe
  output logic burst_step_n, // Burst advance
  output logic global_write_n, // Global write
  output logic byte_write_gate_n, // Byte-write gate
  output logic [LANES-1:0] lane_write_n, // Lane writes
  output logic output_enable_n, // Output enable
  output logic [ADDR_W-1:0] addrIn, // Word address
  output logic [DATA_W-1:0] wdata // Data the master puts out
);
  logic rude = 1'b0; // Set only by scenarios that break the master's duties
  logic lowSelOff = 1'b0; // Low-active select driven inactive by deselect scenarios
  logic wrTerm; // Pins ask for a write
  ////////////////////////////////////////////////
  // Quiet, unselected bus at time zero
  initial begin
    {primary_select_n, high_active_select, low_active_select_n} = 3'h6;
    {cpu_address_strobe_n, ctrl_address_strobe_n, burst_step_n} = 3'h7;
    {global_write_n, byte_write_gate_n, lane_write_n} = 6'h3F;
    {output_enable_n, wrTerm} = 2'h2;
    addrIn = ADDR_RST;
    wdata = DATA_RST;
  end
  ////////////////////////////////////////////////
  // One bus cycle, held over the following rising edge
  task automatic put(input logic [4:0] ctl, input logic [5:0] wr, input logic oe,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [5:0] w;
    w = (ctl[2] | rude) ? wr : 6'h3F; // no write term with the processor strobe
    @(negedge clk_sys);
    {primary_select_n, high_active_select} = ctl[4:3];
    low_active_select_n = lowSelOff;
    {cpu_address_strobe_n, ctrl_address_strobe_n, burst_step_n} = ctl[2:0];
    {global_write_n, byte_write_gate_n, lane_write_n} = w;
    wrTerm = !w[5] || (!w[4] && w[3:0] != 4'hF);
    output_enable_n = oe | (wrTerm & !rude); // float drivers before write data
    addrIn = a;
    // Released bus flips every cycle so stale data never looks valid
    wdata = wrTerm ? d : ~wdata;
  endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench of the burst SRAM cycle decoder.
// Assumes the master model on the pins and a combinational array below.
`timescale 1ns/1ps
module tb
  import sbsram_pkg::*;
;
  logic clk_sys = 1'b0; // System clock
  logic rst = 1'b1; // Reset, held at start
  logic sleep_request = 1'b0; // Sleep pin
  logic burst_order = 1'b0; // 1 interleaved, 0 linear
  logic primary_select_n, high_active_select, low_active_select_n; // Selects
  logic cpu_address_strobe_n, ctrl_address_strobe_n, burst_step_n; // Burst control
  logic global_write_n, byte_write_gate_n, output_enable_n; // Write and enable
  logic [LANES-1:0] lane_write_n, memLaneWe; // Lane controls
  logic [ADDR_W-1:0] addrIn, memAddr; // Addresses
  logic [DATA_W-1:0] dqIn, dqOut, memWdata, memRdata, wdata; // Data
  logic dqOe_n, sleepActive; // Status
  int mismatches = 0; // Failed comparisons
  int numChecks = 0; // All comparisons
  int cycles = 0; // Cycles since start
  ////////////////////////////////////////////////
  // Array contents derived from the address
  function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
    return {a[16:0], a};
  endfunction
  assign memRdata = rd(memAddr);
  // Common data wire: the decoder wins only while it drives
  assign dqIn = !dqOe_n ? dqOut : wdata;
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  sbsram_master_model i_mst (.clk_sys, .primary_select_n, .high_active_select,
    .low_active_select_n, .cpu_address_strobe_n, .ctrl_address_strobe_n, .burst_step_n,
    .global_write_n, .byte_write_gate_n, .lane_write_n, .output_enable_n, .addrIn, .wdata);
  sbsram_cycle_decode i_dut (.clk_sys, .rst, .primary_select_n, .high_active_select,
    .low_active_select_n, .sleep_request, .cpu_address_strobe_n, .ctrl_address_strobe_n,
    .burst_step_n, .global_write_n, .byte_write_gate_n, .lane_write_n, .burst_order,
    .output_enable_n, .addrIn, .dqIn, .dqOut, .dqOe_n, .memAddr, .memLaneWe, .memWdata,
    .memRdata, .sleepActive);
  ////////////////////////////////////////////////
  // Compare one value, report a difference at once
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle, then let the rising edge's updates land
  task automatic cy(input logic [4:0] ctl, input logic [5:0] wr, input logic oe,
                    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_mst.put(ctl, wr, oe, a, d);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////
  // Controller-strobe starts with every kind of write term
  task automatic t_write();
    logic [5:0] wr [6] = '{6'h1F, 6'h2E, 6'h25, 6'h20, 6'h30, 6'h2F};
    logic [LANES-1:0] exp;
    for (int i = 0; i < 6; i++) begin
      exp = !wr[i][5] ? LANES_ALL : (!wr[i][4] ? ~wr[i][3:0] : LANES_NONE);
      cy(5'h0D, wr[i], 1'b1, 19'h00100 + ADDR_W'(i), 36'h123456789 + DATA_W'(i));
      chk(DATA_W'(memLaneWe), DATA_W'(exp));
      chk(DATA_W'(memAddr), DATA_W'(19'h00100 + ADDR_W'(i)));
      if (exp != LANES_NONE) chk(memWdata, 36'h123456789 + DATA_W'(i));
    end
    // Processor start reads; its write follows on the next clock as a continue
    cy(5'h0B, 6'h1F, 1'b1, 19'h00500, 36'h0);
    chk(DATA_W'(memLaneWe), '0);
    cy(5'h1E, 6'h1F, 1'b1, 19'h00000, 36'h0FEDCBA98);
    chk(DATA_W'(memLaneWe), DATA_W'(LANES_ALL));
    chk(DATA_W'(memAddr), DATA_W'(19'h00501));
    chk(memWdata, 36'h0FEDCBA98);
  endtask
  // Read bursts in both orders with write pins low at the start
  task automatic t_burst();
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] prev;
    for (int m = 0; m < 2; m++) begin
      @(negedge clk_sys);
      burst_order = m[0];
      i_mst.rude = 1'b1;
      cy(5'h0B, 6'h00, 1'b0, 19'h2A5F1, '0);
      i_mst.rude = 1'b0;
      chk(DATA_W'(memLaneWe), '0);
      chk(DATA_W'(memAddr), DATA_W'(19'h2A5F1));
      prev = 19'h2A5F1;
      a = 19'h2A5F1;
      // Fourth step wraps back to the seed
      for (int k = 1; k < 5; k++) begin
        a[1:0] = m[0] ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
        cy(5'h1E, 6'h3F, 1'b0, ~19'h2A5F1, '0);
        chk(DATA_W'(memAddr), DATA_W'(a));
        chk(dqOut, rd(prev));
        chk(DATA_W'(dqOe_n), '0);
        prev = a;
      end
      cy(5'h1F, 6'h3F, 1'b0, '0, '0);
      chk(DATA_W'(memAddr), DATA_W'(a));
    end
    // No clock edge between enable and pin state
    @(negedge clk_sys);
    i_mst.output_enable_n = 1'b1;
    #1;
    chk(DATA_W'(dqOe_n), 36'h1);
  endtask
  // Writes with output enable left low keep the drivers off
  task automatic t_guard();
    i_mst.rude = 1'b1;
    cy(5'h0D, 6'h20, 1'b0, 19'h00200, 36'hABCDE1234);
    chk(DATA_W'(dqOe_n), 36'h1);
    cy(5'h1E, 6'h2E, 1'b0, '0, 36'h5);
    chk(DATA_W'(dqOe_n), 36'h1);
    chk(DATA_W'(memLaneWe), 36'h1);
    i_mst.rude = 1'b0;
  endtask
  // Every deselect form ends the burst and floats the pins
  task automatic t_deselect();
    logic [4:0] ds [3] = '{5'h1D, 5'h03, 5'h0D};
    for (int i = 0; i < 3; i++) begin
      cy(5'h0B, 6'h3F, 1'b0, 19'h00300, '0);
      i_mst.lowSelOff = (i == 2); // Third form: low-active select off
      cy(ds[i], 6'h3F, 1'b0, 19'h00300, '0);
      i_mst.lowSelOff = 1'b0;
      cy(5'h1E, 6'h3F, 1'b0, '0, '0);
      chk(DATA_W'(dqOe_n), 36'h1);
      cy(5'h1E, 6'h20, 1'b1, '0, 36'h5);
      chk(DATA_W'(memLaneWe), '0);
    end
  endtask
  // Sleep floats the pins at once, then takes the device down
  task automatic t_sleep();
    cy(5'h0B, 6'h3F, 1'b0, 19'h00400, '0);
    cy(5'h1F, 6'h3F, 1'b0, '0, '0);
    @(negedge clk_sys);
    sleep_request = 1'b1;
    #1;
    chk(DATA_W'(dqOe_n), 36'h1);
    repeat (5) @(posedge clk_sys);
    #1;
    chk(DATA_W'(sleepActive), 36'h1);
    @(negedge clk_sys);
    sleep_request = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk(DATA_W'(sleepActive), '0);
  endtask
  ////////////////////////////////////////////////
  // Main sequence: reset for ten cycles, then every scenario
  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_write();
    t_burst();
    t_guard();
    t_deselect();
    t_sleep();
    complete_run();
  end
  // Run needs about 60 cycles; far beyond that means a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end
endmodule
